/* File: lpd_ctl.sv */
`timescale 1ns/1ns
module lpd_ctl (
    input wire logic clk_in,
    input wire logic rst_in,
    lpd_link_if.ctl link,
    input wire logic req_valid_in,
    input wire logic [3:0] req_cmd_in,
    input wire logic [1:0] req_ba_in,
    input wire logic [lpd_pkg::AW-1:0] req_addr_in,
    output logic req_ready_out,
    output logic req_taken_out,
    output logic [lpd_pkg::DW-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic [lpd_pkg::DW-1:0] status_word_out,
    output logic [3:0] refresh_mult_out
);
    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    logic [3:0] div_q;
    logic slot_p;
    logic take;
    logic ok;
    assign slot_p = link.ck && div_q == 4'(lpd_pkg::CK_HALF_CYC - 1);
    // Ready lags the request by a cycle, so the live check guards a freshly changed command
    assign take = slot_p && req_valid_in && req_ready_out && ok;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_q <= 4'h0;
            link.ck <= 1'b0;
        end
        else if (div_q == 4'(lpd_pkg::CK_HALF_CYC - 1))
        begin
            div_q <= 4'h0;
            link.ck <= ~link.ck;
        end
        else
            div_q <= div_q + 4'h1;
    end

    // ----------------------------------------
    // Command issue on the falling link edge
    // ----------------------------------------
    logic [3:0] wait_q;
    logic [3:0] act_wait_q;
    logic [3:0] open_q;
    logic stat_q;
    logic [3:0] rd_left_q;
    logic [2:0] cl_q;
    logic [2:0] bl_code_q;

    always_comb
    begin
        ok = wait_q == 4'h0;
        case (req_cmd_in)
            lpd_pkg::CMD_ACT: ok = ok && !stat_q && !open_q[req_ba_in] && act_wait_q == 4'h0;
            lpd_pkg::CMD_RD: ok = ok && (stat_q || open_q[req_ba_in]);
            lpd_pkg::CMD_WR: ok = ok && !stat_q && open_q[req_ba_in] && rd_left_q == 4'h0;
            lpd_pkg::CMD_LMR: ok = ok && !stat_q && open_q == 4'h0 && rd_left_q == 4'h0;
            lpd_pkg::CMD_NOP: ok = ok;
            default: ok = ok && !stat_q;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= lpd_pkg::CMD_NOP;
            link.ba <= 2'h0;
            link.addr <= '0;
            req_ready_out <= 1'b0;
            req_taken_out <= 1'b0;
            wait_q <= 4'h0;
            act_wait_q <= 4'h0;
            open_q <= 4'h0;
            stat_q <= 1'b0;
            rd_left_q <= 4'h0;
            cl_q <= lpd_pkg::CL_RST;
            bl_code_q <= lpd_pkg::BL_RST;
        end
        else
        begin
            req_ready_out <= ok;
            req_taken_out <= take;
            if (slot_p)
            begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= take ? req_cmd_in : lpd_pkg::CMD_NOP;
                link.ba <= req_ba_in;
                link.addr <= req_addr_in;
                wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
                act_wait_q <= (act_wait_q != 4'h0) ? act_wait_q - 4'h1 : 4'h0;
                rd_left_q <= (rd_left_q != 4'h0) ? rd_left_q - 4'h1 : 4'h0;
            end
            if (take)
            begin
                case (req_cmd_in)
                    lpd_pkg::CMD_ACT:
                    begin
                        open_q[req_ba_in] <= 1'b1;
                        wait_q <= lpd_pkg::T_RCD_CK; // see RULE12
                        act_wait_q <= lpd_pkg::T_RC_CK; // see RULE13 see RULE14
                    end
                    lpd_pkg::CMD_PRE:
                    begin
                        if (req_addr_in[lpd_pkg::AP_BIT])
                            open_q <= 4'h0;
                        else
                            open_q[req_ba_in] <= 1'b0;
                        wait_q <= lpd_pkg::T_RP_CK; // see RULE22
                    end
                    lpd_pkg::CMD_RD:
                    begin
                        rd_left_q <= 4'(cl_q) + 4'(1 << bl_code_q >> 1);
                        if (stat_q)
                        begin
                            stat_q <= 1'b0;
                            wait_q <= lpd_pkg::T_SRC_CK; // see RULE8
                        end
                        else if (req_addr_in[lpd_pkg::AP_BIT])
                            open_q[req_ba_in] <= 1'b0;
                    end
                    lpd_pkg::CMD_BST: rd_left_q <= 4'(cl_q); // see RULE21
                    lpd_pkg::CMD_LMR:
                    begin
                        if (req_ba_in == lpd_pkg::BA_STAT) // see RULE7
                        begin
                            stat_q <= 1'b1;
                            wait_q <= lpd_pkg::T_SRR_CK; // see RULE8
                        end
                        else
                            wait_q <= lpd_pkg::T_MRD_CK; // see RULE24
                        if (req_ba_in == lpd_pkg::BA_MODE)
                        begin
                            cl_q <= req_addr_in[lpd_pkg::MODE_CL_LSB +: 3];
                            bl_code_q <= req_addr_in[lpd_pkg::MODE_BL_LSB +: 3];
                        end
                    end
                    default: wait_q <= wait_q;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read data capture on strobe edges
    // ----------------------------------------
    logic [lpd_pkg::DW+1:0] in_s1_q;
    logic [lpd_pkg::DW+1:0] in_s2_q;
    logic dqs_s3_q;
    logic cap_stat_q;
    logic beat_p;
    assign beat_p = in_s2_q[lpd_pkg::DW+1] && (in_s2_q[lpd_pkg::DW] != dqs_s3_q);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            in_s1_q <= '0;
            in_s2_q <= '0;
            dqs_s3_q <= 1'b0;
            cap_stat_q <= 1'b0;
            rd_data_out <= '0;
            rd_valid_out <= 1'b0;
            status_word_out <= '0;
            refresh_mult_out <= 4'h0;
        end
        else
        begin
            in_s1_q <= {link.dq_oe, link.dqs, link.dq};
            in_s2_q <= in_s1_q;
            dqs_s3_q <= in_s2_q[lpd_pkg::DW];
            rd_valid_out <= beat_p;
            if (beat_p)
                rd_data_out <= in_s2_q[lpd_pkg::DW-1:0];
            if (take && req_cmd_in == lpd_pkg::CMD_RD && stat_q)
                cap_stat_q <= 1'b1;
            else if (beat_p && cap_stat_q)
            begin
                // Only the first beat carries status: see RULE9
                cap_stat_q <= 1'b0;
                status_word_out <= in_s2_q[lpd_pkg::DW-1:0];
                refresh_mult_out <= in_s2_q[lpd_pkg::SRR_MULT_LSB +: 4]; // see RULE11
            end
        end
    end
endmodule

/* File: lpd_dev.sv */
// Function
// RULE1: Load-mode with bank pair 10 writes config word
// RULE2: Config word held; cleared at deep power-down
// RULE3: Temperature compensation bits written but ignored
// RULE4: Self refresh covers selected partial region only
// RULE5: Reads reach whole array regardless of selection
// RULE6: Drive strength full, three-quarter, half selectable
// RULE7: Status load-mode only with banks idle
// RULE8: Only NOPs around status read waits
// RULE9: Status returns burst of two after latency
// RULE10: Status word holds id, multiplier, width, density
// RULE11: Controller scales refresh interval by multiplier; the controller here only passes it out on refresh_mult_out
// RULE12: Activate row, wait before read or write
// RULE13: Same bank activate needs precharge, spacing
// RULE14: Other bank activate allowed with spacing
// RULE15: Auto-precharge closes row after burst
// RULE16: First data after latency, two per clock
// RULE17: Strobe preamble low, postamble low, then release
// RULE18: Read cut by read, write, terminate, precharge
// RULE19: Later read x cycles after gives seamless data
// RULE20: Burst terminate stops output after read latency
// RULE21: Read finishes or terminates before a write
// RULE22: Precharge x cycles after read, then wait
// RULE23: Read latency of two or three cycles
// RULE24: Load-mode only idle, then wait before next
`timescale 1ns/1ns
module lpd_dev #(
    parameter logic [3:0] MAKER_ID = 4'h5, // Arbitrary value
    parameter logic [3:0] REV_ID = 4'h1, // Arbitrary value
    parameter logic WIDTH_TYPE = 1'b0,
    parameter logic [2:0] DENSITY = 3'h3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    lpd_link_if.dev link,
    input wire logic dpd_in,
    input wire logic [3:0] refresh_mult_in,
    output logic [2:0] partial_refresh_select_out,
    output logic [3:0] refresh_bank_mask_out,
    output logic [1:0] refresh_row_top_zero_out,
    output logic [5:0] drive_ohm_out,
    output logic [3:0] bank_open_out
);
    localparam int PW = 1 + 4 + 2 + lpd_pkg::AW;

    typedef struct packed {
        lpd_pkg::lpd_kind_t kind;
        logic ap;
        logic [1:0] bank;
        logic [lpd_pkg::AW-1:0] col;
    } lpd_entry_t;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    logic [PW-1:0] pins_s1_q;
    logic [PW-1:0] pins_s2_q;
    logic ck_s3_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
            ck_s3_q <= 1'b0;
        end
        else
        begin
            pins_s1_q <= {link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr};
            pins_s2_q <= pins_s1_q;
            ck_s3_q <= pins_s2_q[PW-1];
        end
    end

    logic rise_p;
    logic fall_p;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [lpd_pkg::AW-1:0] addr;
    assign rise_p = pins_s2_q[PW-1] & ~ck_s3_q;
    assign fall_p = ~pins_s2_q[PW-1] & ck_s3_q;
    assign cmd = pins_s2_q[PW-2 -: 4];
    assign ba = pins_s2_q[lpd_pkg::AW +: 2];
    assign addr = pins_s2_q[lpd_pkg::AW-1:0];

    // ----------------------------------------
    // Mode word and extended_config_word
    // ----------------------------------------
    logic [2:0] bl_code_q;
    logic [2:0] cl_q;
    logic [2:0] prs_q;
    logic [2:0] ds_q;
    logic stat_arm_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bl_code_q <= lpd_pkg::BL_RST;
            cl_q <= lpd_pkg::CL_RST;
            prs_q <= lpd_pkg::PRS_RST;
            ds_q <= lpd_pkg::DS_RST;
            stat_arm_q <= 1'b0;
        end
        else if (dpd_in)
        begin
            prs_q <= lpd_pkg::PRS_RST; // see RULE2
            ds_q <= lpd_pkg::DS_RST; // see RULE2
            stat_arm_q <= 1'b0;
        end
        else if (rise_p && cmd == lpd_pkg::CMD_LMR)
        begin
            if (ba == lpd_pkg::BA_MODE)
            begin
                bl_code_q <= addr[lpd_pkg::MODE_BL_LSB +: 3];
                if (addr[lpd_pkg::MODE_CL_LSB +: 3] inside {3'h2, 3'h3}) // see RULE23
                    cl_q <= addr[lpd_pkg::MODE_CL_LSB +: 3];
            end
            else if (ba == lpd_pkg::BA_ECW)
            begin
                // Temperature compensation field is not stored: see RULE3
                prs_q <= addr[lpd_pkg::ECW_PRS_LSB +: 3]; // see RULE1
                ds_q <= addr[lpd_pkg::ECW_DS_LSB +: 3]; // see RULE1
            end
            else if (ba == lpd_pkg::BA_STAT)
                stat_arm_q <= 1'b1;
        end
        else if (rise_p && cmd == lpd_pkg::CMD_RD)
            stat_arm_q <= 1'b0;
    end

    // Self refresh coverage and drive figures
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            partial_refresh_select_out <= lpd_pkg::PRS_RST;
            refresh_bank_mask_out <= 4'hF;
            refresh_row_top_zero_out <= 2'h0;
            drive_ohm_out <= lpd_pkg::DS_FULL_OHM;
        end
        else
        begin
            partial_refresh_select_out <= prs_q;
            case (prs_q) // see RULE4
                lpd_pkg::PRS_HALF: {refresh_bank_mask_out, refresh_row_top_zero_out} <= 6'h0C;
                lpd_pkg::PRS_QTR: {refresh_bank_mask_out, refresh_row_top_zero_out} <= 6'h04;
                lpd_pkg::PRS_8TH: {refresh_bank_mask_out, refresh_row_top_zero_out} <= 6'h05;
                lpd_pkg::PRS_16TH: {refresh_bank_mask_out, refresh_row_top_zero_out} <= 6'h07;
                default: {refresh_bank_mask_out, refresh_row_top_zero_out} <= 6'h3C;
            endcase
            case (ds_q) // see RULE6
                lpd_pkg::DS_3Q: drive_ohm_out <= lpd_pkg::DS_3Q_OHM;
                lpd_pkg::DS_HALF: drive_ohm_out <= lpd_pkg::DS_HALF_OHM;
                default: drive_ohm_out <= lpd_pkg::DS_FULL_OHM;
            endcase
        end
    end

    // ----------------------------------------
    // Command latency pipeline
    // ----------------------------------------
    lpd_entry_t pipe_q [0:2];
    lpd_entry_t new_e;
    lpd_entry_t pre_e;
    lpd_entry_t stop_e;
    logic [1:0] last_bank_q;
    logic last_ap_q;

    always_comb
    begin
        new_e = '{kind: lpd_pkg::LPD_K_NONE, ap: addr[lpd_pkg::AP_BIT], bank: ba, col: addr};
        if (cmd == lpd_pkg::CMD_RD)
            new_e.kind = stat_arm_q ? lpd_pkg::LPD_K_STAT : lpd_pkg::LPD_K_READ; // see RULE5
        else if (cmd == lpd_pkg::CMD_BST || cmd == lpd_pkg::CMD_WR) // see RULE18
            new_e.kind = lpd_pkg::LPD_K_STOP;
        else if (cmd == lpd_pkg::CMD_PRE && ba == last_bank_q && !last_ap_q) // see RULE18
            new_e.kind = lpd_pkg::LPD_K_STOP;
    end

    // Latency 2 looks one stage earlier than latency 3: see RULE23
    assign pre_e = (cl_q == 3'h2) ? pipe_q[0] : pipe_q[1];
    assign stop_e = (cl_q == 3'h2) ? pipe_q[1] : pipe_q[2];

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < 3; i++)
                pipe_q[i] <= '0;
            last_bank_q <= 2'h0;
            last_ap_q <= 1'b0;
        end
        else if (rise_p)
        begin
            pipe_q[0] <= new_e;
            for (int i = 1; i < 3; i++)
                pipe_q[i] <= pipe_q[i-1];
            if (cmd == lpd_pkg::CMD_RD)
            begin
                last_bank_q <= ba;
                last_ap_q <= addr[lpd_pkg::AP_BIT];
            end
        end
    end

    // ----------------------------------------
    // Read burst engine
    // ----------------------------------------
    logic pend_q;
    lpd_entry_t pend_e_q;
    lpd_entry_t cur_q;
    logic act_q;
    logic [4:0] beat_q;
    logic [4:0] len_q;
    logic pre_start;
    logic [4:0] bl_len;
    logic [lpd_pkg::DW-1:0] status_word;

    assign pre_start = pre_e.kind inside {lpd_pkg::LPD_K_READ, lpd_pkg::LPD_K_STAT};
    assign bl_len = 5'(1 << bl_code_q);
    assign status_word = { // see RULE10
        DENSITY, WIDTH_TYPE, refresh_mult_in, REV_ID, MAKER_ID
    };

    function automatic logic [lpd_pkg::DW-1:0] beat_word(lpd_entry_t e, logic [4:0] beat,
                                                          logic [4:0] len);
        logic [lpd_pkg::AW-1:0] m;
        logic [lpd_pkg::AW-1:0] c;
        m = lpd_pkg::AW'(len - 5'h01);
        c = (e.col & ~m) | ((e.col + lpd_pkg::AW'(beat)) & m);
        if (e.kind == lpd_pkg::LPD_K_STAT)
            beat_word = (beat == 5'h00) ? status_word : '0; // see RULE9
        else
            beat_word = {e.bank, c};
    endfunction

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_q <= 1'b0;
            pend_e_q <= '0;
            cur_q <= '0;
            act_q <= 1'b0;
            beat_q <= 5'h00;
            len_q <= 5'h00;
            link.dq <= '0;
            link.dq_oe <= 1'b0;
            link.dqs <= 1'b0;
            link.dqs_oe <= 1'b0;
        end
        else if (rise_p)
        begin
            pend_q <= pre_start;
            pend_e_q <= pre_e;
            if (pend_q)
            begin
                // New burst takes over seamlessly: see RULE19
                cur_q <= pend_e_q;
                act_q <= 1'b1;
                beat_q <= 5'h01;
                len_q <= (pend_e_q.kind == lpd_pkg::LPD_K_STAT) ? lpd_pkg::STATUS_LEN : bl_len;
                link.dq <= beat_word(pend_e_q, 5'h00, bl_len); // see RULE16
                link.dq_oe <= 1'b1;
                link.dqs <= 1'b1;
                link.dqs_oe <= 1'b1;
            end
            else if (act_q && beat_q < len_q && stop_e.kind != lpd_pkg::LPD_K_STOP) // see RULE20
            begin
                link.dq <= beat_word(cur_q, beat_q, len_q);
                link.dqs <= 1'b1;
                beat_q <= beat_q + 5'h01;
            end
            else
            begin
                // Release after the postamble, or hold low as the next preamble
                act_q <= 1'b0;
                link.dq_oe <= 1'b0;
                link.dqs <= 1'b0; // see RULE17
                link.dqs_oe <= pre_start; // see RULE17
            end
        end
        else if (fall_p && act_q && beat_q < len_q)
        begin
            link.dq <= beat_word(cur_q, beat_q, len_q); // see RULE16
            link.dqs <= 1'b0;
            beat_q <= beat_q + 5'h01;
        end
    end

    // ----------------------------------------
    // Open rows
    // ----------------------------------------
    logic ap_done;
    assign ap_done = rise_p && !pend_q && act_q && beat_q == len_q && cur_q.ap;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            bank_open_out <= 4'h0;
        else if (rise_p && cmd == lpd_pkg::CMD_ACT)
            bank_open_out[ba] <= 1'b1;
        else if (rise_p && cmd == lpd_pkg::CMD_PRE)
        begin
            if (addr[lpd_pkg::AP_BIT])
                bank_open_out <= 4'h0;
            else
                bank_open_out[ba] <= 1'b0;
        end
        else if (ap_done)
            bank_open_out[cur_q.bank] <= 1'b0; // see RULE15
    end
endmodule

/* File: lpd_link_if.sv */
`timescale 1ns/1ns
interface lpd_link_if;
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [lpd_pkg::AW-1:0] addr;
    logic [lpd_pkg::DW-1:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    modport dev (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, output dq, dq_oe, dqs, dqs_oe);
    modport ctl (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, input dq, dq_oe, dqs, dqs_oe);
endinterface

/* File: lpd_link_sva.sv */
`timescale 1ns/1ns
module lpd_link_sva (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic dq_oe,
    input wire logic dqs,
    input wire logic dqs_oe
);
    logic [3:0] cmd;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // Commands are looked at on link clock rises, which come every 8 system clocks
    a_rcd_wait: assert property ($rose(ck) && cmd == lpd_pkg::CMD_ACT
        |-> ##8 !(cmd == lpd_pkg::CMD_RD && ba == $past(ba, 8))) else $error("read inside trcd");
    a_act_space: assert property ($rose(ck) && cmd == lpd_pkg::CMD_ACT
        |-> ##8 cmd != lpd_pkg::CMD_ACT ##8 cmd != lpd_pkg::CMD_ACT
        ##8 cmd != lpd_pkg::CMD_ACT ##8 cmd != lpd_pkg::CMD_ACT) else $error("activate spacing");
    a_stat_nop: assert property ($rose(ck) && cmd == lpd_pkg::CMD_LMR
        && ba == lpd_pkg::BA_STAT |-> ##8 cmd == lpd_pkg::CMD_NOP) else $error("status setup");
    a_data_strobe: assert property (dq_oe |-> dqs_oe) else $error("data without strobe");
    a_preamble: assert property ($rose(dqs_oe) |-> !dqs [*8] ##1 dqs)
        else $error("bad preamble");
    a_strobe_hold: assert property (dqs_oe && $changed(dqs)
        |=> (!dqs_oe || $stable(dqs)) [*3]) else $error("strobe beat too short");
    a_read_lat: assert property ($rose(ck) && cmd == lpd_pkg::CMD_RD
        |-> ##[20:34] dq_oe) else $error("read data late");
    a_bst_stop: assert property ($rose(ck) && cmd == lpd_pkg::CMD_BST
        |-> ##[20:28] !dq_oe) else $error("burst not stopped");
endmodule

/* File: lpd_pkg.sv */
package lpd_pkg;
    localparam int AW = 14;
    localparam int DW = 16;
    // Link clock made by the controller from the system clock
    localparam int CLK_NS = 20;
    localparam int CK_PERIOD_NS = 160;
    localparam int CK_HALF_CYC = CK_PERIOD_NS / (2 * CLK_NS);
    // Command pins {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_LMR = 4'h0;
    // Bank select pair {bank_select_high, bank_select_low} on a load-mode
    localparam logic [1:0] BA_MODE = 2'h0;
    localparam logic [1:0] BA_STAT = 2'h1;
    localparam logic [1:0] BA_ECW = 2'h2;
    // Base mode word fields
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] BL_RST = 3'h2;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam int AP_BIT = 10;
    // extended_config_word fields
    localparam int ECW_PRS_LSB = 0;
    localparam int ECW_TCR_LSB = 3;
    localparam int ECW_DS_LSB = 5;
    localparam logic [2:0] PRS_RST = 3'h0;
    localparam logic [2:0] DS_RST = 3'h0;
    localparam logic [2:0] PRS_FULL = 3'h0;
    localparam logic [2:0] PRS_HALF = 3'h1;
    localparam logic [2:0] PRS_QTR = 3'h2;
    localparam logic [2:0] PRS_8TH = 3'h5;
    localparam logic [2:0] PRS_16TH = 3'h6;
    localparam logic [2:0] DS_FULL = 3'h0;
    localparam logic [2:0] DS_3Q = 3'h1;
    localparam logic [2:0] DS_HALF = 3'h2;
    localparam logic [5:0] DS_FULL_OHM = 6'h19;
    localparam logic [5:0] DS_3Q_OHM = 6'h25;
    localparam logic [5:0] DS_HALF_OHM = 6'h37;
    // status_readback_word fields
    localparam int SRR_MAKER_LSB = 0;
    localparam int SRR_REV_LSB = 4;
    localparam int SRR_MULT_LSB = 8;
    localparam int SRR_WIDTH_BIT = 12;
    localparam int SRR_DENS_LSB = 13;
    localparam logic [4:0] STATUS_LEN = 5'h02;
    // Controller waits in link clock cycles
    localparam logic [3:0] T_MRD_CK = 4'h2;
    localparam logic [3:0] T_SRR_CK = 4'h2;
    localparam logic [3:0] T_SRC_CK = 4'h4;
    localparam logic [3:0] T_RCD_CK = 4'h2;
    localparam logic [3:0] T_RP_CK = 4'h2;
    localparam logic [3:0] T_RC_CK = 4'h5;
    typedef enum logic [1:0] {LPD_K_NONE, LPD_K_READ, LPD_K_STAT, LPD_K_STOP} lpd_kind_t;
endpackage

/* File: test_lpddr_ext_mode_status_read_path.sv */
`timescale 1ns/1ns
module test_lpddr_ext_mode_status_read_path;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: %h vs %h", $time, (g), (e)); end end
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic valid = 1'b0;
    logic [3:0] cmd = lpd_pkg::CMD_NOP;
    logic [1:0] ba = 2'h0;
    logic [13:0] addr = 14'h0000;
    logic dpd = 1'b0;
    logic [3:0] mult = 4'h0;
    logic taken, rdv, rdy;
    logic [15:0] stat, rd_d, last_d, exp_d;
    logic [13:0] ra;
    logic [1:0] rtop;
    logic [3:0] rmul, mask, bopen;
    logic [2:0] psel;
    logic [5:0] ohm;
    logic [31:0] seed = 32'h6C9E, r;
    int fail_count = 0, n_tests = 0;
    int beats = 0, base = 0;
    logic [2:0] prs_t [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [3:0] mask_t [5] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
    logic [1:0] top_t [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    logic [5:0] ohm_t [3] = '{6'h19, 6'h25, 6'h37};
    // Read cases: command one slot after the read, beats seen, row left open
    logic [3:0] sec_t [5] = '{lpd_pkg::CMD_PRE, lpd_pkg::CMD_NOP, lpd_pkg::CMD_BST,
        lpd_pkg::CMD_RD, lpd_pkg::CMD_NOP};
    int beat_t [5] = '{2, 4, 2, 6, 4};
    logic [4:0] open_t = 5'h0E;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in)
        beats <= beats + int'(rdv === 1'b1);
    always @(posedge clk_in)
        if (rdv === 1'b1)
            last_d <= rd_d;
    lpd_link_if lpd_link_if_i ();
    // Identity parameter values are arbitrary
    lpd_dev #(.MAKER_ID(4'hA), .REV_ID(4'h3), .WIDTH_TYPE(1'b1), .DENSITY(3'h4)) lpd_dev_i (
        .clk_in(clk_in), .rst_in(rst_in), .link(lpd_link_if_i), .dpd_in(dpd),
        .refresh_mult_in(mult), .partial_refresh_select_out(psel), .refresh_bank_mask_out(mask),
        .refresh_row_top_zero_out(rtop), .drive_ohm_out(ohm), .bank_open_out(bopen));
    lpd_ctl lpd_ctl_i (.clk_in(clk_in), .rst_in(rst_in), .link(lpd_link_if_i),
        .req_valid_in(valid), .req_cmd_in(cmd), .req_ba_in(ba), .req_addr_in(addr),
        .req_ready_out(rdy), .req_taken_out(taken), .rd_data_out(rd_d), .rd_valid_out(rdv),
        .status_word_out(stat), .refresh_mult_out(rmul));
    lpd_link_sva lpd_link_sva_i (.clk_in(clk_in), .rst_in(rst_in), .ck(lpd_link_if_i.ck),
        .cs_n(lpd_link_if_i.cs_n), .ras_n(lpd_link_if_i.ras_n), .cas_n(lpd_link_if_i.cas_n),
        .we_n(lpd_link_if_i.we_n), .ba(lpd_link_if_i.ba), .dq_oe(lpd_link_if_i.dq_oe),
        .dqs(lpd_link_if_i.dqs), .dqs_oe(lpd_link_if_i.dqs_oe));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Beat n of a burst of four: bank over the column with its low bits wrapped
    function automatic logic [15:0] exp_last(input logic [1:0] b, input logic [13:0] a,
                                             input int n);
        return {b, a[13:2], a[1:0] + 2'(n - 1)};
    endfunction
    // Holds the request until the controller reports it taken
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
        int n;
        @(posedge clk_in);
        {cmd, ba, addr, valid} <= {c, b, a, 1'b1};
        for (n = 0; n < 400 && taken !== 1'b1; n++)
            @(posedge clk_in);
        fail_count += int'(n == 400);
        valid <= 1'b0;
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            r = xs();
            issue(lpd_pkg::CMD_LMR, lpd_pkg::BA_ECW, {6'h00, 3'(i % 3), r[1:0], prs_t[i]});
            repeat (30) @(posedge clk_in);
            `CHK(ohm, ohm_t[i % 3])
            `CHK(mask, mask_t[i])
            `CHK(rtop, top_t[i])
            `CHK(psel, prs_t[i])
        end
        dpd <= 1'b1;
        repeat (4) @(posedge clk_in);
        dpd <= 1'b0;
        `CHK({psel, ohm}, {3'h0, 6'h19})
        mult <= r[5:2];
        base = beats;
        issue(lpd_pkg::CMD_LMR, lpd_pkg::BA_STAT, 14'h0000);
        @(posedge clk_in);
        `CHK(rdy, 1'b0)
        issue(lpd_pkg::CMD_RD, 2'h0, 14'h0000);
        repeat (60) @(posedge clk_in);
        `CHK({stat, rmul}, {3'h4, 1'b1, r[5:2], 4'h3, 4'hA, r[5:2]})
        `CHK(beats - base, 2)
        `CHK(last_d, 16'h0000)
        issue(lpd_pkg::CMD_LMR, lpd_pkg::BA_ECW, 14'h0006);
        for (int k = 0; k < 5; k++)
        begin
            r = xs();
            base = beats;
            issue(lpd_pkg::CMD_ACT, 2'(k), r[13:0]);
            ra = {3'h0, k == 4, r[9:0]};
            issue(lpd_pkg::CMD_RD, 2'(k), ra);
            if (sec_t[k] != lpd_pkg::CMD_NOP)
                issue(sec_t[k], 2'(k), 14'h0000);
            repeat (80) @(posedge clk_in);
            `CHK(beats - base, beat_t[k])
            `CHK(bopen[k[1:0]], open_t[k])
            exp_d = exp_last(2'(k), (k == 3) ? 14'h0000 : ra,
                beat_t[k] - 2 * int'(k == 3));
            `CHK(last_d, exp_d)
        end
        // Latency two with a terminated burst
        issue(lpd_pkg::CMD_PRE, 2'h0, 14'h0400);
        issue(lpd_pkg::CMD_LMR, lpd_pkg::BA_MODE, 14'h0022);
        issue(lpd_pkg::CMD_ACT, 2'h1, r[13:0]);
        base = beats;
        issue(lpd_pkg::CMD_RD, 2'h1, 14'h0005);
        issue(lpd_pkg::CMD_BST, 2'h1, 14'h0000);
        repeat (21) @(posedge clk_in);
        `CHK(beats - base, 1)
        repeat (60) @(posedge clk_in);
        `CHK(beats - base, 2)
        `CHK(last_d, exp_last(2'h1, 14'h0005, 2))
        print_verdict();
    end
endmodule
